/* ddc_control.sv */
// Drive direction, software disable and emergency timeout control
`timescale 1ns/1ns
`default_nettype none
module ddc_control
    import ddc_pkg::*;
#(
    parameter int TICK_CYC = DDC_TICK_CYC
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Parameter access port
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] addr,
    input wire logic [15:0] wdata,
    output logic [15:0] rdata,
    output logic wr_refused,
    // Drive configuration
    input wire logic analog_drive_type,
    input wire logic restricted_bus_variant,
    input wire logic brake_configured,
    // Motion feedback
    input wire logic home_done,
    input wire logic signed [31:0] current_cmd_in,
    input wire logic signed [31:0] position_fb_in,
    input wire logic [31:0] velocity_feedback,
    input wire logic [31:0] stop_velocity_threshold,
    // Conditioned outputs
    output logic signed [31:0] current_cmd_out,
    output logic signed [31:0] position_fb_out,
    output logic drive_active_status,
    output logic software_enable_bit,
    output logic axis_homed,
    output logic dyn_brake_on,
    output logic pwm_enable,
    output logic holding_brake_close,
    output logic controlled_stop_req,
    output logic fault_active,
    output logic [15:0] fault_code
);
    ddc_state_t st_r, st_nxt;
    logic dir_r, dir_nxt;
    ddc_mode_t mode_r, mode_nxt;
    logic swen_r, swen_nxt;
    logic homed_r, homed_nxt;
    logic flt_r, flt_nxt;
    logic tmr_run_r, tmr_run_nxt;
    logic [15:0] tmo_r, tmo_nxt;
    logic [15:0] ms_r, ms_nxt;
    logic [31:0] tick_r, tick_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    logic refused_r, refused_nxt;
    logic init_r, init_nxt;
    logic [31:0] vel_abs;
    logic slow, wr_dir, wr_dis, wr_mode, wr_en_cmd, enabled, reached;
    logic [1:0] mode_max;

    assign vel_abs = velocity_feedback[31] ? 32'(-velocity_feedback) : velocity_feedback;
    assign slow = vel_abs < stop_velocity_threshold;
    assign enabled = (st_r != DDC_ST_DISABLED) && (st_r != DDC_ST_DB_HOLD);
    assign wr_dir = wr_en && addr == DDC_ADDR_DIR;
    assign wr_dis = wr_en && addr == DDC_ADDR_DIS;
    assign wr_mode = wr_en && addr == DDC_ADDR_MODE;
    assign wr_en_cmd = wr_en && addr == DDC_ADDR_EN;
    assign mode_max = restricted_bus_variant ? DDC_MODE_MAX_RESTR : DDC_MODE_MAX; // RL11
    assign reached = st_nxt == DDC_ST_DISABLED || st_nxt == DDC_ST_DB_HOLD;

    always_comb begin
        st_nxt = st_r;
        dir_nxt = dir_r;
        mode_nxt = mode_r;
        swen_nxt = swen_r;
        homed_nxt = homed_r;
        tmo_nxt = tmo_r;
        refused_nxt = 1'b0;
        init_nxt = 1'b0;
        if (init_r) begin
            swen_nxt = analog_drive_type; // RL9
            st_nxt = analog_drive_type ? DDC_ST_ENABLED : DDC_ST_DISABLED; // RL9
        end
        if (home_done) begin
            homed_nxt = 1'b1;
        end
        if (wr_dir) begin
            if (enabled || wdata > 16'(DDC_DIR_MAX)) begin
                refused_nxt = 1'b1; // RL2
            end else begin
                dir_nxt = wdata[0]; // RL1
                if (wdata[0] != dir_r) begin
                    homed_nxt = 1'b0; // RL3
                end
            end
        end
        if (wr_mode) begin
            if (enabled || wdata > 16'(mode_max)) begin
                refused_nxt = 1'b1; // RL10 RL13
            end else begin
                mode_nxt = ddc_mode_t'(wdata[1:0]); // RL10
            end
        end
        if (wr_dis || wr_en_cmd || (wr_en && addr == DDC_ADDR_TMO)) begin
            if (wr_en && addr == DDC_ADDR_TMO) begin
                tmo_nxt = wdata;
            end
        end
        case (st_r)
            DDC_ST_ENABLED: begin
                if (wr_dis) begin
                    swen_nxt = 1'b0; // RL4 RL7
                    case (mode_r) // RL5 RL12
                        DDC_MODE_OFF: st_nxt = DDC_ST_DISABLED;
                        DDC_MODE_DYNBRK: st_nxt = DDC_ST_DB_RAMP;
                        default: st_nxt = DDC_ST_CS_RAMP;
                    endcase
                end
            end
            DDC_ST_CS_RAMP: begin
                if (slow) begin
                    st_nxt = (mode_r == DDC_MODE_STOP_DYNBRK) ? DDC_ST_DB_HOLD
                                                              : DDC_ST_DISABLED; // RL12
                end
            end
            DDC_ST_DB_RAMP: st_nxt = DDC_ST_DB_HOLD; // RL12
            DDC_ST_DISABLED, DDC_ST_DB_HOLD: begin
                if (wr_en_cmd) begin
                    swen_nxt = 1'b1; // RL7
                    st_nxt = DDC_ST_ENABLED;
                end
            end
            default: st_nxt = DDC_ST_DISABLED;
        endcase
        if (wr_dis) begin
            swen_nxt = 1'b0; // RL4
        end
    end

    always_comb begin
        tmr_run_nxt = tmr_run_r;
        flt_nxt = flt_r;
        ms_nxt = ms_r;
        tick_nxt = tick_r;
        // Clear first so an expiry in the same cycle still raises the fault
        if (wr_en_cmd && !st_nxt[2] && st_nxt != DDC_ST_DISABLED) begin
            flt_nxt = 1'b0;
        end
        if (wr_dis && enabled && !reached) begin
            tmr_run_nxt = 1'b1; // RL8
            ms_nxt = 16'h0000;
            tick_nxt = 32'h0000_0000;
        end else if (tmr_run_r) begin
            if (reached) begin
                tmr_run_nxt = 1'b0; // RL15
            end else if (ms_r >= tmo_r) begin
                tmr_run_nxt = 1'b0;
                flt_nxt = 1'b1; // RL8
            end else if (tick_r == 32'(TICK_CYC - 1)) begin
                tick_nxt = 32'h0000_0000;
                ms_nxt = ms_r + 16'h0001;
            end else begin
                tick_nxt = tick_r + 32'h0000_0001;
            end
        end
    end

    always_comb begin
        rdata_nxt = rdata_r;
        if (rd_en) begin
            case (addr)
                DDC_ADDR_DIR: rdata_nxt = {15'h0000, dir_r};
                DDC_ADDR_MODE: rdata_nxt = {14'h0000, mode_r};
                DDC_ADDR_TMO: rdata_nxt = tmo_r;
                DDC_ADDR_STAT: begin
                    rdata_nxt = 16'h0000;
                    rdata_nxt[DDC_STAT_ACTIVE] = enabled; // RL6
                    rdata_nxt[DDC_STAT_SWEN] = swen_r; // RL7
                    rdata_nxt[DDC_STAT_HOMED] = homed_r;
                    rdata_nxt[DDC_STAT_FAULT] = flt_r;
                    rdata_nxt[DDC_STAT_DYNBRK] = dyn_brake_on;
                    rdata_nxt[DDC_STAT_BRAKE] = holding_brake_close;
                end
                default: rdata_nxt = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= DDC_ST_DISABLED;
            dir_r <= DDC_DIR_RST;
            mode_r <= ddc_mode_t'(DDC_MODE_RST);
            swen_r <= 1'b0;
            homed_r <= 1'b0;
            flt_r <= 1'b0;
            tmr_run_r <= 1'b0;
            tmo_r <= DDC_TMO_RST;
            ms_r <= 16'h0000;
            tick_r <= 32'h0000_0000;
            rdata_r <= 16'h0000;
            refused_r <= 1'b0;
            init_r <= 1'b1;
        end else begin
            st_r <= st_nxt;
            dir_r <= dir_nxt;
            mode_r <= mode_nxt;
            swen_r <= swen_nxt;
            homed_r <= homed_nxt;
            flt_r <= flt_nxt;
            tmr_run_r <= tmr_run_nxt;
            tmo_r <= tmo_nxt;
            ms_r <= ms_nxt;
            tick_r <= tick_nxt;
            rdata_r <= rdata_nxt;
            refused_r <= refused_nxt;
            init_r <= init_nxt;
        end
    end

    // Sign flip kept combinational so the loop sees no added latency
    assign current_cmd_out = dir_r ? 32'(-current_cmd_in) : current_cmd_in; // RL1
    assign position_fb_out = dir_r ? 32'(-position_fb_in) : position_fb_in; // RL1
    assign rdata = rdata_r;
    assign wr_refused = refused_r;
    assign drive_active_status = enabled; // RL6
    assign software_enable_bit = swen_r;
    assign axis_homed = homed_r;
    assign dyn_brake_on = st_r == DDC_ST_DB_RAMP || st_r == DDC_ST_DB_HOLD;
    assign pwm_enable = st_r != DDC_ST_DISABLED; // RL12
    assign controlled_stop_req = st_r == DDC_ST_CS_RAMP;
    assign holding_brake_close = brake_configured && !(st_r == DDC_ST_ENABLED) && slow; // RL14
    assign fault_active = flt_r;
    assign fault_code = flt_r ? DDC_FAULT_CODE : 16'h0000; // RL8

    property p_dir_sign;
        @(posedge clock) disable iff (!reset_n)
        dir_r |-> current_cmd_out == 32'(-current_cmd_in);
    endproperty
    a_dir_sign: assert property (p_dir_sign) else $error("invert not applied"); // RL1

    property p_dir_refuse;
        @(posedge clock) disable iff (!reset_n)
        (wr_dir && enabled) |=> (dir_r == $past(dir_r)) && wr_refused;
    endproperty
    a_dir_refuse: assert property (p_dir_refuse) else $error("invert changed while on"); // RL2

    property p_unhome;
        @(posedge clock) disable iff (!reset_n)
        $changed(dir_r) |-> !axis_homed;
    endproperty
    a_unhome: assert property (p_unhome) else $error("homed kept after invert"); // RL3

    sequence s_dis_cmd;
        wr_dis && st_r == DDC_ST_ENABLED;
    endsequence
    property p_dis_clear;
        @(posedge clock) disable iff (!reset_n)
        s_dis_cmd |=> !software_enable_bit && st_r != DDC_ST_ENABLED;
    endproperty
    a_dis_clear: assert property (p_dis_clear) else $error("disable not taken"); // RL4

    property p_mode0;
        @(posedge clock) disable iff (!reset_n)
        s_dis_cmd and (mode_r == DDC_MODE_OFF) |=> st_r == DDC_ST_DISABLED;
    endproperty
    a_mode0: assert property (p_mode0) else $error("mode 0 not immediate"); // RL5

    property p_swen_set;
        @(posedge clock) disable iff (!reset_n)
        (wr_en_cmd && !wr_dis && !enabled) |=> software_enable_bit;
    endproperty
    a_swen_set: assert property (p_swen_set) else $error("enable bit not set"); // RL7

    property p_mode_refuse;
        @(posedge clock) disable iff (!reset_n)
        (wr_mode && enabled) |=> mode_r == $past(mode_r);
    endproperty
    a_mode_refuse: assert property (p_mode_refuse) else $error("mode changed while on"); // RL13

    property p_brake;
        @(posedge clock) disable iff (!reset_n)
        (brake_configured && slow && st_r == DDC_ST_DISABLED) |-> holding_brake_close;
    endproperty
    a_brake: assert property (p_brake) else $error("brake not closed"); // RL14

    property p_cancel;
        @(posedge clock) disable iff (!reset_n)
        (tmr_run_r && reached && !flt_r) |=> !tmr_run_r && !fault_active;
    endproperty
    a_cancel: assert property (p_cancel) else $error("timer not cancelled"); // RL15

    property p_fault_raise;
        @(posedge clock) disable iff (!reset_n)
        (tmr_run_r && !wr_dis && !reached && ms_r >= tmo_r) |=> fault_active && fault_code == DDC_FAULT_CODE;
    endproperty
    a_fault_raise: assert property (p_fault_raise) else $error("timeout fault missing"); // RL8

    property p_mode_range;
        @(posedge clock) disable iff (!reset_n)
        (wr_mode && wdata > 16'(mode_max)) |=> mode_r == $past(mode_r) && wr_refused;
    endproperty
    a_mode_range: assert property (p_mode_range) else $error("mode range not kept"); // RL10 RL11

    property p_stat_swen;
        @(posedge clock) disable iff (!reset_n)
        (rd_en && addr == DDC_ADDR_STAT) |=> rdata[DDC_STAT_SWEN] == $past(software_enable_bit);
    endproperty
    a_stat_swen: assert property (p_stat_swen) else $error("status enable bit wrong"); // RL7
endmodule // ddc_control
`default_nettype wire

/* ddc_pkg.sv */
// Constants and types for the drive direction and disable control block
// Operation
// RL1: Invert set to 1 negates current command and position feedback; range 0..1, reset 0.
// RL2: Invert setting writable only while drive disabled; enabled-time writes refused.
// RL3: Any change of invert value clears the homed indication at once.
// RL4: Software disable command clears software enable and starts disabling.
// RL5: Reaction selection chooses immediate disable or ramp down first.
// RL6: Readable active status reports whether drive is enabled.
// RL7: Disable-cause software-enable bit set by enable, cleared by disable.
// RL8: Disable command starts emergency timer; expiry before disable raises fault.
// RL9: After reset software enable asserted only on analog-command drive types.
// RL10: Reaction selection accepts 0..3 and resets to 0.
// RL11: On the restricted fieldbus variant reaction selection accepts only 0..2.
// RL12: Codes: 0 off, 1 dynamic brake, 2 stop then off, 3 stop then brake.
// RL13: Reaction selection writable only while drive disabled.
// RL14: Holding brake closes once velocity feedback falls below stop threshold.
// RL15: Reaching disable or brake state before expiry cancels timer without fault.
package ddc_pkg;
    localparam logic [7:0] DDC_ADDR_DIR = 8'hEA;
    localparam logic [7:0] DDC_ADDR_DIS = 8'hEC;
    localparam logic [7:0] DDC_ADDR_MODE = 8'hEE;
    localparam logic [7:0] DDC_ADDR_EN = 8'hF0;
    localparam logic [7:0] DDC_ADDR_STAT = 8'hF2;
    localparam logic [7:0] DDC_ADDR_TMO = 8'hF4;
    localparam logic [0:0] DDC_DIR_RST = 1'h0;
    localparam logic [0:0] DDC_DIR_MAX = 1'h1;
    localparam logic [1:0] DDC_MODE_RST = 2'h0;
    localparam logic [1:0] DDC_MODE_MAX = 2'h3;
    localparam logic [1:0] DDC_MODE_MAX_RESTR = 2'h2;
    localparam logic [15:0] DDC_TMO_RST = 16'h03E8;
    localparam logic [15:0] DDC_FAULT_CODE = 16'h0703;
    localparam int DDC_STAT_ACTIVE = 0;
    localparam int DDC_STAT_SWEN = 1;
    localparam int DDC_STAT_HOMED = 2;
    localparam int DDC_STAT_FAULT = 3;
    localparam int DDC_STAT_BRAKE = 4;
    localparam int DDC_STAT_DYNBRK = 5;
    localparam int DDC_MS_PER_TICK = 1;
    localparam int DDC_CLK_MHZ = 100;
    localparam int DDC_TICK_CYC = DDC_MS_PER_TICK * DDC_CLK_MHZ * 1000;
    typedef enum logic [1:0] {
        DDC_MODE_OFF = 2'b00,
        DDC_MODE_DYNBRK = 2'b01,
        DDC_MODE_STOP_OFF = 2'b10,
        DDC_MODE_STOP_DYNBRK = 2'b11
    } ddc_mode_t;
    typedef enum logic [2:0] {
        DDC_ST_DISABLED = 3'b000,
        DDC_ST_ENABLED = 3'b001,
        DDC_ST_DB_RAMP = 3'b010,
        DDC_ST_CS_RAMP = 3'b011,
        DDC_ST_DB_HOLD = 3'b100
    } ddc_state_t;
endpackage : ddc_pkg

/* ddc_host_model.sv */
// Host controller model issuing parameter accesses
`timescale 1ns/1ns
`default_nettype none
module ddc_host_model (
    // Clock
    input wire logic clock,
    // Access port
    output logic wr_en,
    output logic rd_en,
    output logic [7:0] addr,
    output logic [15:0] wdata,
    input wire logic [15:0] rdata,
    input wire logic wr_refused
);
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 8'h00;
        wdata = 16'h0000;
    end
    // Released lines show inverted values, never a stale copy
    task automatic write(input logic [7:0] a, input logic [15:0] d, output logic refused);
        @(posedge clock);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr_en <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
        #1 refused = wr_refused;
        @(posedge clock);
        #1 refused = refused | wr_refused;
    endtask
    task automatic read(input logic [7:0] a, output logic [15:0] d);
        @(posedge clock);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd_en <= 1'b0;
        addr <= ~a;
        @(posedge clock);
        #1 d = rdata;
    endtask
endmodule // ddc_host_model
`default_nettype wire

/* tb_drive_direction_disable_control.sv */
// Testbench for the direction and disable control block
`timescale 1ns/1ns
`default_nettype none
module tb_drive_direction_disable_control;
    import ddc_pkg::*;
    logic clock, reset_n, wr_en, rd_en, wr_refused, analog_drive_type, restricted_bus_variant;
    logic brake_configured, home_done, drive_active_status, software_enable_bit, axis_homed;
    logic dyn_brake_on, pwm_enable, holding_brake_close, controlled_stop_req, fault_active;
    logic [7:0] addr;
    logic [15:0] wdata, rdata, fault_code;
    logic signed [31:0] current_cmd_in, position_fb_in, current_cmd_out, position_fb_out;
    logic [31:0] velocity_feedback, stop_velocity_threshold;
    int bad_count, check_count;
    ddc_control #(.TICK_CYC(10)) ddc_control_inst (
        .clock(clock), .reset_n(reset_n), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
        .wdata(wdata), .rdata(rdata), .wr_refused(wr_refused),
        .analog_drive_type(analog_drive_type), .restricted_bus_variant(restricted_bus_variant),
        .brake_configured(brake_configured), .home_done(home_done),
        .current_cmd_in(current_cmd_in), .position_fb_in(position_fb_in),
        .velocity_feedback(velocity_feedback), .stop_velocity_threshold(stop_velocity_threshold),
        .current_cmd_out(current_cmd_out), .position_fb_out(position_fb_out),
        .drive_active_status(drive_active_status), .software_enable_bit(software_enable_bit),
        .axis_homed(axis_homed), .dyn_brake_on(dyn_brake_on), .pwm_enable(pwm_enable),
        .holding_brake_close(holding_brake_close), .controlled_stop_req(controlled_stop_req),
        .fault_active(fault_active), .fault_code(fault_code));
    ddc_host_model ddc_host_model_inst (
        .clock(clock), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata),
        .rdata(rdata), .wr_refused(wr_refused));
    task automatic end_of_test();
        if (bad_count == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check_bit(input string name, input logic e, input logic g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %b seen %b", name, e, g);
        end
    endtask
    task automatic check_word(input string name, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m = 16'hFFFF);
        logic [15:0] d;
        ddc_host_model_inst.read(a, d);
        check_word("read", {16'h0000, e & m}, {16'h0000, d & m});
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic e);
        logic r;
        ddc_host_model_inst.write(a, d, r);
        check_bit("refused", e, r);
    endtask
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        end_of_test();
    end
    initial begin
        reset_n = 1'b0;
        analog_drive_type = 1'b0;
        restricted_bus_variant = 1'b0;
        brake_configured = 1'b1;
        home_done = 1'b0;
        current_cmd_in = 32'h00000005;
        position_fb_in = 32'h00000007;
        velocity_feedback = 32'h00000000;
        stop_velocity_threshold = 32'h00000064;
        repeat (10) @(posedge clock);
        reset_n <= 1'b1;
        repeat (2) @(posedge clock);
        #1;
        check_bit("swen", 1'b0, software_enable_bit);
        rd(DDC_ADDR_DIR, 16'h0000);
        rd(DDC_ADDR_MODE, 16'h0000);
        rd(DDC_ADDR_STAT, 16'h0000, 16'h000F);
        rd(DDC_ADDR_TMO, DDC_TMO_RST);
        wr(DDC_ADDR_TMO, 16'h0003, 1'b0);
        rd(DDC_ADDR_TMO, 16'h0003);
        @(posedge clock);
        home_done <= 1'b1;
        @(posedge clock);
        home_done <= 1'b0;
        #1;
        check_bit("homed", 1'b1, axis_homed);
        wr(DDC_ADDR_DIR, 16'h0001, 1'b0);
        check_bit("homed", 1'b0, axis_homed);
        check_word("cur", 32'hFFFFFFFB, current_cmd_out);
        check_word("pos", 32'hFFFFFFF9, position_fb_out);
        wr(DDC_ADDR_DIR, 16'h0002, 1'b1);
        rd(DDC_ADDR_DIR, 16'h0001);
        wr(DDC_ADDR_DIR, 16'h0000, 1'b0);
        check_word("cur", 32'h00000005, current_cmd_out);
        @(posedge clock);
        restricted_bus_variant <= 1'b1;
        wr(DDC_ADDR_MODE, 16'h0003, 1'b1);
        wr(DDC_ADDR_MODE, 16'h0002, 1'b0);
        restricted_bus_variant <= 1'b0;
        wr(DDC_ADDR_MODE, 16'h0004, 1'b1);
        for (int m = 0; m < 4; m++) begin
            wr(DDC_ADDR_MODE, 16'(m), 1'b0);
            rd(DDC_ADDR_MODE, 16'(m));
            velocity_feedback <= 32'h000003E8;
            wr(DDC_ADDR_EN, 16'h0001, 1'b0);
            check_bit("active", 1'b1, drive_active_status);
            check_bit("swen", 1'b1, software_enable_bit);
            check_bit("brake", 1'b0, holding_brake_close);
            rd(DDC_ADDR_STAT, 16'h0003, 16'h0003);
            wr(DDC_ADDR_DIR, 16'h0001, 1'b1);
            wr(DDC_ADDR_MODE, 16'h0000, 1'b1);
            wr(DDC_ADDR_DIS, 16'h0001, 1'b0);
            check_bit("swen", 1'b0, software_enable_bit);
            check_bit("stop", m > 1, controlled_stop_req);
            check_bit("active", m > 1, drive_active_status);
            velocity_feedback <= 32'h00000000;
            repeat (5) @(posedge clock);
            #1;
            check_bit("dynbrk", m[0], dyn_brake_on);
            check_bit("pwm", m[0], pwm_enable);
            check_bit("active", 1'b0, drive_active_status);
            check_bit("brake", 1'b1, holding_brake_close);
            repeat (40) @(posedge clock);
            #1;
            check_bit("fault", 1'b0, fault_active);
        end
        wr(DDC_ADDR_MODE, 16'h0002, 1'b0);
        velocity_feedback <= 32'h000003E8;
        wr(DDC_ADDR_EN, 16'h0001, 1'b0);
        wr(DDC_ADDR_DIS, 16'h0001, 1'b0);
        repeat (60) @(posedge clock);
        #1;
        check_bit("fault", 1'b1, fault_active);
        check_word("code", 32'h00000703, {16'h0000, fault_code});
        rd(DDC_ADDR_STAT, 16'h0008, 16'h0008);
        @(posedge clock);
        reset_n <= 1'b0;
        analog_drive_type <= 1'b1;
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        repeat (2) @(posedge clock);
        #1;
        check_bit("swen", 1'b1, software_enable_bit);
        check_bit("active", 1'b1, drive_active_status);
        end_of_test();
    end
endmodule // tb_drive_direction_disable_control
`default_nettype wire
